//--- design/dsflb_regs.vh
// Parameter numbers, widths and timing constants of the drive status and fault log bank.
`ifndef DSFLB_REGS_VH
`define DSFLB_REGS_VH

`define DSFLB_IDX_W             8
`define DSFLB_DATA_W            48

`define DSFLB_IDX_LS_POSITION   8'h5E
`define DSFLB_IDX_LS_ONE_STATE  8'h5F
`define DSFLB_IDX_LS_TWO_STATE  8'h60
`define DSFLB_IDX_APPLIED_DUTY  8'h68
`define DSFLB_IDX_RAW_DUTY      8'h69
`define DSFLB_IDX_RUN_TIME      8'h94
`define DSFLB_IDX_RESET_COUNT   8'h95
`define DSFLB_IDX_INT_ERR_COUNT 8'h96
`define DSFLB_IDX_SHORT_COUNT   8'h97
`define DSFLB_IDX_OVERSH_COUNT  8'h98
`define DSFLB_IDX_UNDERV_COUNT  8'h99
`define DSFLB_IDX_OVERV_COUNT   8'h9A
`define DSFLB_IDX_OVERT_COUNT   8'h9B

`define DSFLB_POS_W             32
`define DSFLB_DUTY_W            16
`define DSFLB_DUTY_SCALE        16'h2000
`define DSFLB_RUN_W             48
`define DSFLB_LOG_W             16
`define DSFLB_LOG_MAX           16'hFFFF
`define DSFLB_RUN_MAX           48'hFFFFFFFFFFFF
`define DSFLB_NUM_LOGS          7

`define DSFLB_CLK_PERIOD_PS     5000
`define DSFLB_RUN_TICK_MS       1
`define DSFLB_RUN_TICK_CYCLES   ((`DSFLB_RUN_TICK_MS * 1000000000) / `DSFLB_CLK_PERIOD_PS)

`endif

//--- design/dsflb_status_bank.v
// Read-only status and fault log parameter bank of the servo drive.
//
// What this block does
// - Report limit switch position as signed 32 bits, kept within zero..rollover when set.
// - Report each limit switch output as one bit, 1 while that output is active.
// - In pulse-width command mode report applied duty as signed fraction scaled by 8192.
// - Applied duty is derived from measured duty after polarity and inversion are applied.
// - Report raw measured duty as unsigned 0..8192, before polarity or inversion.
// - Keep a 48-bit run-time counter advancing once per millisecond of operation.
// - Keep a 16-bit counter incremented once per drive reset event.
// - Keep separate 16-bit counters for six fault events, one increment per occurrence.
//
// Access port behaviour.
// A request is taken at a rising edge with reqValid high; reqWrite and reqIndex are
// sampled at that same edge.
// The answer appears exactly one cycle later: ackValid is high for one cycle only.
// ackError and ackData hold their values until the next answer is given.
// Requests may be made back to back, one per cycle, in any order.
// Every value is returned as one 48-bit word with narrow values in the low bits.
// Upper bits of narrow values are always zero, including the position value.
// Any write, and any read of an unknown number, is answered with an error and zero data.
//
// Value timing.
// Limit switch states and position are registered once per cycle, so a read sees the
// value that stood at the inputs one cycle before the request edge.
// Duty values are captured only on cycles with a measurement strobe.
// An event input that is high for n cycles counts as n occurrences.
// The run-time counter advances one cycle after each divider tick.
//
// Limitations.
// The rollover fold is applied once per cycle, so a position step larger than one
// rollover span within a single cycle is not fully folded.
// The run time is lost on reset; keeping it across power cycles is left to the system.
// Outside pulse-width command mode both duty values read as zero.
//
`timescale 1ns/1ps
`default_nettype none
`include "dsflb_regs.vh"

module dsflb_status_bank #(
  parameter [31:0] RUN_TICK_CYCLES = `DSFLB_RUN_TICK_CYCLES
) (
  input  wire                          clk,              // System clock, 200 MHz.
  input  wire                          resetn,           // Synchronous reset, active low.
  input  wire                          reqValid,         // Parameter access request strobe.
  input  wire                          reqWrite,         // 1 for a write attempt, 0 for a read.
  input  wire [`DSFLB_IDX_W-1:0]       reqIndex,         // Parameter number.
  output reg                           ackValid,         // Answer strobe, one cycle.
  output reg                           ackError,         // Unknown number or refused write.
  output reg  [`DSFLB_DATA_W-1:0]      ackData,          // Read value, zero-extended.
  input  wire [`DSFLB_POS_W-1:0]       limitPosition,    // Raw position counts, signed.
  input  wire                          rolloverEnable,   // Rollover range is defined.
  input  wire [`DSFLB_POS_W-1:0]       rolloverValue,    // Rollover value, positive.
  input  wire                          limitOutOne,      // First limit switch output active.
  input  wire                          limitOutTwo,      // Second limit switch output active.
  input  wire                          pwmCommandMode,   // Pulse-width command input selected.
  input  wire                          dutyValid,        // New measured duty sample.
  input  wire [`DSFLB_DUTY_W-1:0]      dutyMeasured,     // Measured duty, 0..8192.
  input  wire                          dutyPolarity,     // Low time counts as positive.
  input  wire                          dutyInvert,       // Negate the signed command.
  input  wire                          driveRunning,     // Drive is operating.
  input  wire                          evtDriveReset,    // Drive reset event pulse.
  input  wire                          evtInternalError, // Internal error event pulse.
  input  wire                          evtShortCircuit,  // Short circuit event pulse.
  input  wire                          evtOvershoot,     // Current overshoot event pulse.
  input  wire                          evtUnderVoltage,  // Hardware under voltage pulse.
  input  wire                          evtOverVoltage,   // Hardware over voltage pulse.
  input  wire                          evtOverTemp       // Drive over temperature pulse.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  // The saturating increment is shared by all seven fault log counters.
  // A counter at its maximum stays there, so a long burst of events never wraps it
  // back to a small value that would hide the burst.

  function [`DSFLB_LOG_W-1:0] satInc16;
    input [`DSFLB_LOG_W-1:0] value;
    input                    hit;
    begin
      if (hit && value != `DSFLB_LOG_MAX) begin
        satInc16 = value + 16'h0001;
      end else begin
        satInc16 = value;
      end
    end
  endfunction

  function [`DSFLB_DATA_W-1:0] zext16;
    input [15:0] value;
    begin
      zext16 = {32'h00000000, value};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Limit switch position and outputs.

  reg  [`DSFLB_POS_W-1:0] prevPos_reg;
  reg  [`DSFLB_POS_W-1:0] wrapPos_reg;
  reg  [`DSFLB_POS_W-1:0] wrapPos_next;
  reg  [`DSFLB_POS_W-1:0] shownPos_reg;
  reg                     lsOne_reg;
  reg                     lsTwo_reg;
  reg                     posPrimed_reg;
  wire [`DSFLB_POS_W-1:0] posDelta;
  wire [`DSFLB_POS_W-1:0] posSum;

  // Rollover tracking follows per-cycle motion; a step larger than one rollover
  // span in a single cycle is folded only once.
  // The raw input is differenced against the previous cycle rather than folded by
  // division, which keeps the logic small and free of a divider.
  // The first cycle after reset, or any cycle with rollover off, reloads the raw
  // value so that tracking starts from a known point.
  assign posDelta = limitPosition - prevPos_reg;
  assign posSum   = wrapPos_reg + posDelta;

  always @* begin
    wrapPos_next = posSum;
    if ($signed(posSum) < 0) begin
      wrapPos_next = posSum + rolloverValue;
    end else if ($signed(posSum) > $signed(rolloverValue)) begin
      wrapPos_next = posSum - rolloverValue;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      prevPos_reg   <= 32'h00000000;
      wrapPos_reg   <= 32'h00000000;
      shownPos_reg  <= 32'h00000000;
      posPrimed_reg <= 1'b0;
      lsOne_reg     <= 1'b0;
      lsTwo_reg     <= 1'b0;
    end else begin
      prevPos_reg   <= limitPosition;
      posPrimed_reg <= 1'b1;
      lsOne_reg     <= limitOutOne;
      lsTwo_reg     <= limitOutTwo;
      if (!rolloverEnable || !posPrimed_reg) begin
        wrapPos_reg  <= limitPosition;
        shownPos_reg <= limitPosition;
      end else begin
        wrapPos_reg  <= wrapPos_next;
        shownPos_reg <= wrapPos_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duty cycle, raw and applied.

  reg  [`DSFLB_DUTY_W-1:0] rawDuty_reg;
  reg  [`DSFLB_DUTY_W-1:0] appliedDuty_reg;
  wire [`DSFLB_DUTY_W-1:0] dutyClamped;
  wire [`DSFLB_DUTY_W-1:0] dutyPolar;
  wire [`DSFLB_DUTY_W-1:0] dutySigned;
  wire [`DSFLB_DUTY_W-1:0] dutyApplied;

  // Measurements above full scale are clamped so both values stay in range.
  // Polarity swaps high and low time, inversion negates the signed command.
  // The signed value is twice the duty minus full scale, so half duty reads zero.
  assign dutyClamped = (dutyMeasured > `DSFLB_DUTY_SCALE) ? `DSFLB_DUTY_SCALE : dutyMeasured;
  assign dutyPolar   = dutyPolarity ? (`DSFLB_DUTY_SCALE - dutyClamped) : dutyClamped;
  assign dutySigned  = {dutyPolar[14:0], 1'b0} - `DSFLB_DUTY_SCALE;
  assign dutyApplied = dutyInvert ? (16'h0000 - dutySigned) : dutySigned;

  always @(posedge clk) begin
    if (!resetn) begin
      rawDuty_reg     <= 16'h0000;
      appliedDuty_reg <= 16'h0000;
    end else if (!pwmCommandMode) begin
      rawDuty_reg     <= 16'h0000;
      appliedDuty_reg <= 16'h0000;
    end else if (dutyValid) begin
      rawDuty_reg     <= dutyClamped;
      appliedDuty_reg <= dutyApplied;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run time and fault log counters.

  reg  [31:0]              tickCount_reg;
  reg                      msTick_reg;
  reg  [`DSFLB_RUN_W-1:0]  runTime_reg;
  reg  [`DSFLB_LOG_W-1:0]  logCount_reg [0:`DSFLB_NUM_LOGS-1];
  wire [`DSFLB_NUM_LOGS-1:0] logEvent;
  integer                  i;

  assign logEvent = {evtOverTemp, evtOverVoltage, evtUnderVoltage, evtOvershoot,
                     evtShortCircuit, evtInternalError, evtDriveReset};

  // The millisecond divider only runs while the drive operates, so idle time is not counted.
  // The divider count is kept while the drive is stopped, so short runs add up.
  // The tick is registered and the counter advances on the edge after it.
  always @(posedge clk) begin
    if (!resetn) begin
      tickCount_reg <= 32'h00000000;
      msTick_reg    <= 1'b0;
    end else if (!driveRunning) begin
      msTick_reg    <= 1'b0;
    end else if (tickCount_reg >= RUN_TICK_CYCLES - 32'h00000001) begin
      tickCount_reg <= 32'h00000000;
      msTick_reg    <= 1'b1;
    end else begin
      tickCount_reg <= tickCount_reg + 32'h00000001;
      msTick_reg    <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      runTime_reg <= 48'h000000000000;
      for (i = 0; i < `DSFLB_NUM_LOGS; i = i + 1) begin
        logCount_reg[i] <= 16'h0000;
      end
    end else begin
      if (msTick_reg && runTime_reg != `DSFLB_RUN_MAX) begin
        runTime_reg <= runTime_reg + 48'h000000000001;
      end
      logCount_reg[0] <= satInc16(logCount_reg[0], logEvent[0]);
      for (i = 1; i < `DSFLB_NUM_LOGS; i = i + 1) begin
        logCount_reg[i] <= satInc16(logCount_reg[i], logEvent[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter access port.

  reg [`DSFLB_DATA_W-1:0] readValue;
  reg                     readHit;

  always @* begin
    readValue = 48'h000000000000;
    readHit   = 1'b1;
    case (reqIndex)
      `DSFLB_IDX_LS_POSITION:   readValue = {16'h0000, shownPos_reg};
      `DSFLB_IDX_LS_ONE_STATE:  readValue = {47'h000000000000, lsOne_reg};
      `DSFLB_IDX_LS_TWO_STATE:  readValue = {47'h000000000000, lsTwo_reg};
      `DSFLB_IDX_APPLIED_DUTY:  readValue = zext16(appliedDuty_reg);
      `DSFLB_IDX_RAW_DUTY:      readValue = zext16(rawDuty_reg);
      `DSFLB_IDX_RUN_TIME:      readValue = runTime_reg;
      `DSFLB_IDX_RESET_COUNT:   readValue = zext16(logCount_reg[0]);
      `DSFLB_IDX_INT_ERR_COUNT: readValue = zext16(logCount_reg[1]);
      `DSFLB_IDX_SHORT_COUNT:   readValue = zext16(logCount_reg[2]);
      `DSFLB_IDX_OVERSH_COUNT:  readValue = zext16(logCount_reg[3]);
      `DSFLB_IDX_UNDERV_COUNT:  readValue = zext16(logCount_reg[4]);
      `DSFLB_IDX_OVERV_COUNT:   readValue = zext16(logCount_reg[5]);
      `DSFLB_IDX_OVERT_COUNT:   readValue = zext16(logCount_reg[6]);
      default:                  readHit   = 1'b0;
    endcase
  end

  // Writes are answered with an error and touch no stored value.
  // No stored value has a write path, so no write can disturb a counter.
  // ackError and ackData hold between requests so a slow reader can still sample them.
  always @(posedge clk) begin
    if (!resetn) begin
      ackValid <= 1'b0;
      ackError <= 1'b0;
      ackData  <= 48'h000000000000;
    end else begin
      ackValid <= reqValid;
      if (reqValid) begin
        ackError <= reqWrite || !readHit;
        ackData  <= (reqWrite || !readHit) ? 48'h000000000000 : readValue;
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/dsflb_chk.sv
// Port assertions for the drive status bank.
`timescale 1ns/1ps
`default_nettype none
module dsflb_chk (
  input wire logic        clk,        // Clock.
  input wire logic        resetn,     // Reset.
  input wire logic        reqValid,   // Request.
  input wire logic        reqWrite,   // Write flag.
  input wire logic [7:0]  reqIndex,   // Number.
  input wire logic        ackValid,   // Answer.
  input wire logic        ackError,   // Error.
  input wire logic [47:0] ackData,    // Value.
  input wire logic        limitOutOne // Switch one.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rd  = reqValid && !reqWrite;
  wire logic hit = reqIndex inside {[8'h5E:8'h60], 8'h68, 8'h69, [8'h94:8'h9B]};
  sequence s_rd(logic [7:0] n);
    rd && reqIndex == n;
  endsequence
  property p_lat; reqValid |=> ackValid; endproperty
  property p_quiet; !reqValid |=> !ackValid; endproperty
  property p_wr; reqValid && reqWrite |=> ackError && ackData == 48'h0; endproperty
  property p_unmap; rd && !hit |=> ackError && ackData == 48'h0; endproperty
  property p_map; rd && hit |=> !ackError; endproperty
  property p_narrow;
    rd && hit && reqIndex != 8'h5E && reqIndex != 8'h94 |=> ackData[47:16] == 32'h0;
  endproperty
  property p_one; s_rd(8'h5F) |=> ackData == {47'h0, $past(limitOutOne, 2)}; endproperty
  property p_raw; s_rd(8'h69) |=> ackData <= 48'h2000; endproperty
  a_lat: assert property (p_lat) else $error("missing answer");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_wr: assert property (p_wr) else $error("write not refused");
  a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
  a_map: assert property (p_map) else $error("mapped read refused");
  a_narrow: assert property (p_narrow) else $error("upper bits set");
  a_one: assert property (p_one) else $error("switch one state wrong");
  a_raw: assert property (p_raw) else $error("raw duty above scale");
endmodule
bind dsflb_status_bank dsflb_chk u_chk (.clk(clk), .resetn(resetn), .reqValid(reqValid),
  .reqWrite(reqWrite), .reqIndex(reqIndex), .ackValid(ackValid), .ackError(ackError),
  .ackData(ackData), .limitOutOne(limitOutOne));
`default_nettype wire

//--- tb/dsflb_master_model.sv
// Network master model that reads and writes status parameters.
`timescale 1ns/1ps
`default_nettype none
module dsflb_master_model (
  input  wire logic        clk,      // Clock.
  output var  logic        reqValid, // Request.
  output var  logic        reqWrite, // Write flag.
  output var  logic [7:0]  reqIndex, // Number.
  input  wire logic        ackValid, // Answer.
  input  wire logic        ackError, // Error.
  input  wire logic [47:0] ackData   // Value.
);
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqIndex = 8'h00;
  end
  // A missing answer returns unknowns so that every comparison fails.
  task automatic access(input logic wr, input logic [7:0] idx, output logic [47:0] data,
                        output logic err);
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqIndex = idx;
    @(negedge clk);
    reqValid = 1'b0;
    reqWrite = ~wr;
    reqIndex = ~idx;
    err = ackValid ? ackError : 1'bx;
    data = ackValid ? ackData : 48'hX;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the drive status bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, resetn, reqValid, reqWrite, ackValid, ackError, rdErr;
  logic        rolloverEnable, limitOutOne, limitOutTwo, pwmCommandMode, dutyValid;
  logic        dutyPolarity, dutyInvert, driveRunning;
  logic [7:0]  reqIndex;
  logic [47:0] ackData, rdData, runA;
  logic [31:0] limitPosition, rolloverValue;
  logic [15:0] dutyMeasured;
  logic [6:0]  evt;
  int          err_total = 0, n_tests = 0, cyc = 0;
  dsflb_status_bank #(.RUN_TICK_CYCLES(4)) dut (.clk(clk), .resetn(resetn),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqIndex(reqIndex), .ackValid(ackValid),
    .ackError(ackError), .ackData(ackData), .limitPosition(limitPosition),
    .rolloverEnable(rolloverEnable), .rolloverValue(rolloverValue), .limitOutOne(limitOutOne),
    .limitOutTwo(limitOutTwo), .pwmCommandMode(pwmCommandMode), .dutyValid(dutyValid),
    .dutyMeasured(dutyMeasured), .dutyPolarity(dutyPolarity), .dutyInvert(dutyInvert),
    .driveRunning(driveRunning), .evtDriveReset(evt[0]), .evtInternalError(evt[1]),
    .evtShortCircuit(evt[2]), .evtOvershoot(evt[3]), .evtUnderVoltage(evt[4]),
    .evtOverVoltage(evt[5]), .evtOverTemp(evt[6]));
  dsflb_master_model mst (.clk(clk), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqIndex(reqIndex), .ackValid(ackValid), .ackError(ackError), .ackData(ackData));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [7:0] idx, input logic [47:0] exp);
    mst.access(1'b0, idx, rdData, rdErr);
    chk({47'h0, rdErr}, 48'h0);
    chk(rdData, exp);
  endtask
  task pulse(input int k, input int n);
    @(negedge clk) evt[k] = 1'b1;
    repeat (n) @(negedge clk);
    evt[k] = 1'b0;
  endtask
  task duty(input logic [15:0] d, input logic p, input logic i, input logic [15:0] a,
            input logic [15:0] r);
    @(negedge clk) {dutyMeasured, dutyPolarity, dutyInvert, dutyValid} = {d, p, i, 1'b1};
    @(negedge clk) dutyValid = 1'b0;
    rd(8'h68, {32'h0, a});
    rd(8'h69, {32'h0, r});
  endtask
  task t_counts;
    rd(8'h94, 48'h0);
    for (int k = 0; k < 7; k++) rd(8'h95 + k, 48'h0);
    for (int k = 0; k < 7; k++) pulse(k, k + 1);
    for (int k = 0; k < 7; k++) rd(8'h95 + k, k + 1);
  endtask
  task t_refuse;
    mst.access(1'b1, 8'h97, rdData, rdErr);
    chk(rdData, 48'h0);
    chk({47'h0, rdErr}, 48'h1);
    rd(8'h97, 48'h3);
    mst.access(1'b0, 8'h61, rdData, rdErr);
    chk(rdData, 48'h0);
    chk({47'h0, rdErr}, 48'h1);
  endtask
  task t_limit;
    @(negedge clk) {limitOutOne, limitPosition} = {1'b1, 32'h12345678};
    rd(8'h5F, 48'h1);
    rd(8'h60, 48'h0);
    rd(8'h5E, 48'h12345678);
    @(negedge clk) {limitOutOne, limitOutTwo} = 2'b01;
    rd(8'h5F, 48'h0);
    rd(8'h60, 48'h1);
    @(negedge clk) {rolloverEnable, rolloverValue, limitPosition} = {1'b1, 32'h3E8, 32'h1F4};
    rd(8'h5E, 48'h1F4);
    @(negedge clk) limitPosition = 32'h514;
    rd(8'h5E, 48'h12C);
    @(negedge clk) limitPosition = 32'h44C;
    rd(8'h5E, 48'h64);
  endtask
  task t_run;
    @(negedge clk) driveRunning = 1'b1;
    repeat (40) @(negedge clk);
    driveRunning = 1'b0;
    rd(8'h94, 48'hA);
    runA = rdData;
    chk({47'h0, runA >= 48'h7 && runA <= 48'hA}, 48'h1);
    repeat (20) @(negedge clk);
    rd(8'h94, runA);
  endtask
  initial begin
    {resetn, rolloverEnable, limitOutOne, limitOutTwo, dutyValid, dutyPolarity} = 6'h0;
    {dutyInvert, driveRunning, pwmCommandMode, evt} = 10'h0;
    {limitPosition, rolloverValue, dutyMeasured} = 80'h0;
    repeat (2) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    t_counts();
    t_refuse();
    t_limit();
    pwmCommandMode = 1'b1;
    duty(16'h1800, 1'b0, 1'b0, 16'h1000, 16'h1800);
    duty(16'h1800, 1'b1, 1'b0, 16'hF000, 16'h1800);
    duty(16'h1800, 1'b1, 1'b1, 16'h1000, 16'h1800);
    duty(16'h2328, 1'b0, 1'b1, 16'hE000, 16'h2000);
    @(negedge clk) pwmCommandMode = 1'b0;
    rd(8'h69, 48'h0);
    rd(8'h68, 48'h0);
    t_run();
    pulse(6, 65540);
    rd(8'h9B, 48'hFFFF);
    rd(8'h9A, 48'h6);
    tally_and_finish();
  end
endmodule
`default_nettype wire
